// ===== hdl/orx_core.sv
// execution core for or, stack, return and rotate instructions
`timescale 1ns/1ps
module orx_core
  import orx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        instr_valid,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  operand1,
  input  wire logic [7:0]  operand2,
  input  wire logic [7:0]  reg_rdata,
  input  wire logic [7:0]  ind_rdata,
  input  wire logic [7:0]  dir_rdata,
  input  wire logic        dir_is_port,
  input  wire logic [7:0]  port_latch,
  input  wire logic        bit_value,
  input  wire logic [7:0]  ram_rdata,
  input  wire logic        int_pending_low,
  output logic             busy,
  output logic             done,
  output logic [7:0]       acc,
  output logic             carry,
  output logic [7:0]       stack_pointer,
  output logic [15:0]      program_counter,
  output logic [1:0]       instr_len,
  output logic             pc_load,
  output logic             dir_we,
  output logic [7:0]       dir_addr,
  output logic [7:0]       dir_wdata,
  output logic             ram_we,
  output logic [7:0]       ram_addr,
  output logic [7:0]       ram_wdata,
  output logic             prio_release,
  output logic             int_hold,
  output logic             illegal
);
  // ****************************************
  // decode
  // ****************************************
  orx_dec_if dif ();
  orx_decoder u_dec (
    .opcode (opcode),
    .d      (dif)
  );

  typedef enum logic [3:0] {
    ORX_ST_IDLE = 4'b0001,
    ORX_ST_EXEC = 4'b0010,
    ORX_ST_POP2 = 4'b0100,
    ORX_ST_WAIT = 4'b1000
  } orx_state_t;

  orx_state_t  state_r;
  orx_kind_t   kind_r;
  logic [1:0]  cyc_r;
  logic [7:0]  hi_r;
  logic [7:0]  src_byte;
  logic [7:0]  dst_byte;
  logic [7:0]  rot_val;
  logic        rot_cy;
  logic        bit_src;
  logic        start;
  logic        hold_armed_r;
  logic        is_ret;
  logic        pop_to_sp;

  assign start     = ce && instr_valid && (state_r == ORX_ST_IDLE);
  // decoded shorthands
  assign is_ret    = (dif.kind == ORX_K_RET) || (dif.kind == ORX_K_INTERRUPT_EXIT);
  assign pop_to_sp = (operand1 == OP_SP_ADDR);

  // ****************************************
  // operand selection
  // ****************************************
  always_comb begin
    case (dif.src)
      ORX_S_REG: src_byte = reg_rdata;
      ORX_S_DIR: src_byte = dir_rdata;
      ORX_S_IND: src_byte = ind_rdata;
      ORX_S_IMM: src_byte = (dif.kind == ORX_K_OR_DIR) ? operand2 : operand1;
      default:   src_byte = acc;
    endcase
  end

  assign dst_byte = dir_is_port ? port_latch : dir_rdata;
  assign bit_src  = dif.inv_bit ? ~bit_value : bit_value;

  always_comb begin
    rot_val = acc;
    rot_cy  = carry;
    case (dif.rot_mode)
      2'd2: rot_val = {acc[6:0], acc[7]};
      2'd3: {rot_cy, rot_val} = {acc, carry};
      2'd0: rot_val = {acc[0], acc[7:1]};
      default: {rot_val, rot_cy} = {carry, acc};
    endcase
  end

  // ****************************************
  // sequencing
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ORX_ST_IDLE;
      kind_r  <= ORX_K_NONE;
      cyc_r   <= 2'd0;
    end else if (ce) begin
      case (state_r)
        ORX_ST_IDLE: begin
          if (instr_valid) begin
            kind_r <= dif.kind;
            cyc_r  <= dif.ncycles - 2'd1;
            if (is_ret)
              state_r <= ORX_ST_POP2;
            else if (dif.ncycles > 2'd1)
              state_r <= ORX_ST_WAIT;
          end
        end
        ORX_ST_POP2: state_r <= ORX_ST_IDLE;
        ORX_ST_WAIT: begin
          cyc_r <= cyc_r - 2'd1;
          if (cyc_r == 2'd1)
            state_r <= ORX_ST_IDLE;
        end
        default: state_r <= ORX_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      busy <= start ? (dif.ncycles > 2'd1) : (state_r == ORX_ST_WAIT && cyc_r != 2'd1);
      done <= (start && dif.ncycles == 2'd1) || state_r == ORX_ST_POP2 ||
              (state_r == ORX_ST_WAIT && cyc_r == 2'd1);
    end
  end

  // length and legality of the last instruction taken
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      instr_len <= 2'd0;
      illegal   <= 1'b0;
    end else if (start) begin
      instr_len <= dif.nbytes;
      illegal   <= !dif.legal;
    end
  end

  // ****************************************
  // accumulator and carry
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc   <= ACC_RST;
      carry <= 1'b0;
    end else if (start) begin
      case (dif.kind)
        ORX_K_OR_A: acc <= acc | src_byte;
        ORX_K_OR_C: if (bit_src) carry <= 1'b1;
        ORX_K_ROT: begin
          acc   <= rot_val;
          carry <= rot_cy;
        end
        default: acc <= acc;
      endcase
    end
  end

  // ****************************************
  // direct byte writes
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dir_we    <= 1'b0;
      dir_addr  <= BYTE_ZERO;
      dir_wdata <= BYTE_ZERO;
    end else if (ce) begin
      dir_we <= 1'b0;
      if (start && dif.kind == ORX_K_OR_DIR) begin
        dir_we    <= 1'b1;
        dir_addr  <= operand1;
        dir_wdata <= dst_byte | src_byte;
      end else if (start && dif.kind == ORX_K_POP && !pop_to_sp) begin
        dir_we    <= 1'b1;
        dir_addr  <= operand1;
        dir_wdata <= ram_rdata;
      end
    end
  end

  // ****************************************
  // program counter
  // ****************************************
  // loaded only by the second cycle of a return
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      program_counter <= PC_RST;
      pc_load         <= 1'b0;
    end else if (ce) begin
      pc_load <= 1'b0;
      if (state_r == ORX_ST_POP2) begin
        program_counter <= {hi_r, ram_rdata};
        pc_load         <= 1'b1;
      end
    end
  end

  // ****************************************
  // stack pointer and ram port
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stack_pointer <= SP_RST;
      hi_r          <= BYTE_ZERO;
    end else if (ce) begin
      if (start) begin
        case (dif.kind)
          ORX_K_POP: begin
            if (pop_to_sp)
              stack_pointer <= ram_rdata;
            else
              stack_pointer <= stack_pointer - SP_STEP;
          end
          ORX_K_PUSH: stack_pointer <= stack_pointer + SP_STEP;
          ORX_K_RET, ORX_K_INTERRUPT_EXIT: begin
            hi_r          <= ram_rdata;
            stack_pointer <= stack_pointer - SP_STEP;
          end
          default: stack_pointer <= stack_pointer;
        endcase
      end else if (state_r == ORX_ST_POP2) begin
        stack_pointer <= stack_pointer - SP_STEP;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ram_we    <= 1'b0;
      ram_addr  <= SP_RST;
      ram_wdata <= BYTE_ZERO;
    end else if (ce) begin
      ram_we <= 1'b0;
      if (start && dif.kind == ORX_K_PUSH) begin
        ram_we    <= 1'b1;
        ram_addr  <= stack_pointer + SP_STEP;
        ram_wdata <= dir_rdata;
      end else if (start && dif.kind == ORX_K_POP) begin
        ram_addr  <= stack_pointer - SP_STEP;
      end else if (start && is_ret) begin
        ram_addr  <= stack_pointer - SP_STEP; // low byte address for second pop
      end else if (state_r == ORX_ST_POP2) begin
        ram_addr  <= stack_pointer - SP_STEP; // stack top once the return completes
      end else begin
        ram_addr  <= stack_pointer; // idles at the stack top for the next take
      end
    end
  end

  // ****************************************
  // interrupt level release
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prio_release <= 1'b0;
      int_hold     <= 1'b0;
      hold_armed_r <= 1'b0;
    end else if (ce) begin
      prio_release <= 1'b0;
      if (state_r == ORX_ST_POP2 && kind_r == ORX_K_INTERRUPT_EXIT) begin
        prio_release <= 1'b1;
        int_hold     <= int_pending_low;
        hold_armed_r <= int_pending_low;
      end else if (hold_armed_r && instr_valid && state_r == ORX_ST_IDLE) begin
        hold_armed_r <= 1'b0; // one instruction taken
      end else if (!hold_armed_r && done) begin
        int_hold <= 1'b0;
      end
    end
  end
endmodule

// ===== hdl/orx_pkg.sv
// shared constants and types for the or/stack/return/rotate execution block
package orx_pkg;
  // opcodes
  localparam logic [7:0] OP_OR_A_REG     = 8'h48; // low 3 bits select bank register
  localparam logic [7:0] OP_OR_A_DIR     = 8'h45;
  localparam logic [7:0] OP_OR_A_IND     = 8'h46; // low bit selects pointer register
  localparam logic [7:0] OP_OR_A_IMM     = 8'h44;
  localparam logic [7:0] OP_OR_DIR_A     = 8'h42;
  localparam logic [7:0] OP_OR_DIR_IMM   = 8'h43;
  localparam logic [7:0] OP_OR_C_BIT     = 8'h72;
  localparam logic [7:0] OP_OR_C_NBIT    = 8'ha0;
  localparam logic [7:0] OP_POP          = 8'hd0;
  localparam logic [7:0] OP_PUSH         = 8'hc0;
  localparam logic [7:0] OP_CALL_EXIT    = 8'h22;
  localparam logic [7:0] OP_INT_EXIT     = 8'h32;
  localparam logic [7:0] OP_ROT_LEFT     = 8'h23;
  localparam logic [7:0] OP_ROT_LEFT_CY  = 8'h33;
  localparam logic [7:0] OP_ROT_RIGHT    = 8'h03;
  localparam logic [7:0] OP_ROT_RIGHT_CY = 8'h13;
  localparam logic [7:0] OPMASK_REG      = 8'hf8;
  localparam logic [7:0] OPMASK_IND      = 8'hfe;
  localparam logic [7:0] OP_SP_ADDR      = 8'h81; // direct address of the stack pointer
  // reset values
  localparam logic [7:0]  SP_RST  = 8'h07;
  localparam logic [15:0] PC_RST  = 16'h0000;
  localparam logic [7:0]  ACC_RST = 8'h00;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [7:0]  SP_STEP = 8'h01;
  localparam logic [2:0]  BITSEL_ZERO = 3'h0;
  // instruction class codes
  typedef enum logic [3:0] {
    ORX_K_NONE = 4'h0, ORX_K_OR_A = 4'h1, ORX_K_OR_DIR = 4'h2, ORX_K_OR_C = 4'h3,
    ORX_K_POP = 4'h4, ORX_K_PUSH = 4'h5, ORX_K_RET = 4'h6, ORX_K_INTERRUPT_EXIT = 4'h7,
    ORX_K_ROT = 4'h8
  } orx_kind_t;
  typedef enum logic [2:0] {
    ORX_S_A = 3'h0, ORX_S_REG = 3'h1, ORX_S_DIR = 3'h2, ORX_S_IND = 3'h3, ORX_S_IMM = 3'h4
  } orx_src_t;
endpackage

// ===== hdl/orx_dec_if.sv
// decode result carried from the decoder to the executor
`timescale 1ns/1ps
interface orx_dec_if;
  import orx_pkg::*;
  orx_kind_t  kind;
  orx_src_t   src;
  logic       inv_bit;
  logic [2:0] reg_sel;
  logic [1:0] nbytes;
  logic [1:0] ncycles;
  logic [1:0] rot_mode;
  logic       legal;
  modport dec (output kind, src, inv_bit, reg_sel, nbytes, ncycles, rot_mode, legal);
  modport exe (input  kind, src, inv_bit, reg_sel, nbytes, ncycles, rot_mode, legal);
endinterface

// ===== hdl/orx_decoder.sv
// opcode decoder: instruction class, operand source, length and cycle count
`timescale 1ns/1ps
module orx_decoder
  import orx_pkg::*;
(
  input  wire logic [7:0] opcode,
  orx_dec_if.dec          d
);
  always_comb begin
    d.kind     = ORX_K_NONE;
    d.src      = ORX_S_A;
    d.inv_bit  = 1'b0;
    d.reg_sel  = opcode[2:0];
    d.nbytes   = 2'd1;
    d.ncycles  = 2'd1;
    d.rot_mode = opcode[5:4];
    d.legal    = 1'b1;
    if ((opcode & OPMASK_REG) == OP_OR_A_REG) begin
      d.kind = ORX_K_OR_A;
      d.src  = ORX_S_REG;
    end else if ((opcode & OPMASK_IND) == OP_OR_A_IND) begin
      d.kind    = ORX_K_OR_A;
      d.src     = ORX_S_IND;
      d.reg_sel = {2'b00, opcode[0]};
    end else begin
      case (opcode)
        OP_OR_A_DIR: begin
          d.kind    = ORX_K_OR_A;
          d.src     = ORX_S_DIR;
          d.nbytes  = 2'd2;
          d.ncycles = 2'd2;
        end
        OP_OR_A_IMM: begin
          d.kind    = ORX_K_OR_A;
          d.src     = ORX_S_IMM;
          d.nbytes  = 2'd2;
          d.ncycles = 2'd2;
        end
        OP_OR_DIR_A: begin
          d.kind    = ORX_K_OR_DIR;
          d.src     = ORX_S_A;
          d.nbytes  = 2'd2;
          d.ncycles = 2'd2;
        end
        OP_OR_DIR_IMM: begin
          d.kind    = ORX_K_OR_DIR;
          d.src     = ORX_S_IMM;
          d.nbytes  = 2'd3;
          d.ncycles = 2'd3;
        end
        OP_OR_C_BIT: begin
          d.kind    = ORX_K_OR_C;
          d.nbytes  = 2'd2;
          d.ncycles = 2'd2;
        end
        OP_OR_C_NBIT: begin
          d.kind    = ORX_K_OR_C;
          d.inv_bit = 1'b1;
          d.nbytes  = 2'd2;
          d.ncycles = 2'd2;
        end
        OP_POP: begin
          d.kind    = ORX_K_POP;
          d.nbytes  = 2'd2;
          d.ncycles = 2'd2;
        end
        OP_PUSH: begin
          d.kind    = ORX_K_PUSH;
          d.nbytes  = 2'd2;
          d.ncycles = 2'd2;
        end
        OP_CALL_EXIT: begin
          d.kind    = ORX_K_RET;
          d.ncycles = 2'd2;
        end
        OP_INT_EXIT: begin
          d.kind    = ORX_K_INTERRUPT_EXIT;
          d.ncycles = 2'd2;
        end
        OP_ROT_LEFT, OP_ROT_LEFT_CY, OP_ROT_RIGHT, OP_ROT_RIGHT_CY: d.kind = ORX_K_ROT;
        default: d.legal = 1'b0;
      endcase
    end
  end
endmodule

// ===== test/orx_core_monitor.sv
// assertion checker watching the execution core ports
`timescale 1ns/1ps
module orx_core_monitor
  import orx_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic        instr_valid,
  input wire logic [7:0]  opcode,
  input wire logic [7:0]  operand1,
  input wire logic [7:0]  dir_rdata,
  input wire logic        bit_value,
  input wire logic [7:0]  ram_rdata,
  input wire logic        int_pending_low,
  input wire logic        busy,
  input wire logic        done,
  input wire logic [7:0]  acc,
  input wire logic        carry,
  input wire logic [7:0]  stack_pointer,
  input wire logic [15:0] program_counter,
  input wire logic        pc_load,
  input wire logic        dir_we,
  input wire logic [7:0]  dir_addr,
  input wire logic [7:0]  dir_wdata,
  input wire logic        ram_we,
  input wire logic [7:0]  ram_addr,
  input wire logic [7:0]  ram_wdata,
  input wire logic        prio_release,
  input wire logic        int_hold
);
  logic take;
  logic orc;
  logic one;
  assign take = ce && instr_valid && !busy;
  assign orc = opcode == OP_OR_C_BIT || opcode == OP_OR_C_NBIT;
  assign one = (opcode == OP_OR_C_BIT) ? bit_value : !bit_value;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rl;
    take && opcode == OP_ROT_LEFT |=> done && acc == 8'({$past(acc), $past(acc)} >> 7)
      && carry == $past(carry);
  endproperty
  a_rl: assert property (p_rl) else $error("rotate left wrong");
  property p_rlc;
    take && opcode == OP_ROT_LEFT_CY |=> {carry, acc} == {$past(acc), $past(carry)};
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate left via carry wrong");
  property p_rr;
    take && opcode == OP_ROT_RIGHT |=> acc == 8'({$past(acc), $past(acc)} >> 1) && $stable(carry);
  endproperty
  a_rr: assert property (p_rr) else $error("rotate right wrong");
  property p_rrc;
    take && opcode == OP_ROT_RIGHT_CY |=> {acc, carry} == {$past(carry), $past(acc)};
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate right via carry wrong");
  property p_orc_set;
    take && orc && one |-> ##2 carry;
  endproperty
  a_orc_set: assert property (p_orc_set) else $error("carry not set");
  property p_orc_keep;
    take && orc && !one && !carry |=> !carry [*2];
  endproperty
  a_orc_keep: assert property (p_orc_keep) else $error("carry set wrongly");
  property p_push;
    take && opcode == OP_PUSH |=> ram_we && ram_addr == $past(stack_pointer) + 8'h01
      && ram_wdata == $past(dir_rdata) && stack_pointer == ram_addr;
  endproperty
  a_push: assert property (p_push) else $error("push wrong");
  property p_pop;
    take && opcode == OP_POP && operand1 != OP_SP_ADDR |=> dir_we && dir_addr == $past(operand1)
      && dir_wdata == $past(ram_rdata) && stack_pointer == $past(stack_pointer) - 8'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong");
  property p_pop_sp;
    take && opcode == OP_POP && operand1 == OP_SP_ADDR |=> stack_pointer == $past(ram_rdata);
  endproperty
  a_pop_sp: assert property (p_pop_sp) else $error("pop into pointer wrong");
  property p_ret;
    take && (opcode == OP_CALL_EXIT || opcode == OP_INT_EXIT) |-> ##2 pc_load && done
      && program_counter == {$past(ram_rdata, 2), $past(ram_rdata)}
      && stack_pointer == $past(stack_pointer, 2) - 8'h02;
  endproperty
  a_ret: assert property (p_ret) else $error("return wrong");
  property p_interrupt_exit;
    take && opcode == OP_INT_EXIT |-> ##2 prio_release && int_hold == $past(int_pending_low);
  endproperty
  a_interrupt_exit: assert property (p_interrupt_exit) else $error("interrupt exit wrong");
  c_push: cover property (take && opcode == OP_PUSH);
  c_pop_sp: cover property (take && opcode == OP_POP && operand1 == OP_SP_ADDR);
  c_interrupt_exit: cover property (take && opcode == OP_INT_EXIT && int_pending_low);
endmodule
bind orx_core orx_core_monitor orx_core_monitor_i (
  .clk(clk), .rstn(rstn), .ce(ce), .instr_valid(instr_valid), .opcode(opcode),
  .operand1(operand1), .dir_rdata(dir_rdata), .bit_value(bit_value), .ram_rdata(ram_rdata),
  .int_pending_low(int_pending_low), .busy(busy), .done(done), .acc(acc), .carry(carry),
  .stack_pointer(stack_pointer), .program_counter(program_counter), .pc_load(pc_load),
  .dir_we(dir_we), .dir_addr(dir_addr), .dir_wdata(dir_wdata), .ram_we(ram_we),
  .ram_addr(ram_addr), .ram_wdata(ram_wdata), .prio_release(prio_release),
  .int_hold(int_hold)
);

// ===== test/orx_core_test.sv
// self-checking bench of the execution core
`timescale 1ns/1ps
module orx_core_test;
  import orx_pkg::*;
  logic        clk, rstn, ce, instr_valid, dir_is_port, bit_value, int_pending_low;
  logic [7:0]  opcode, operand1, operand2, reg_rdata, ind_rdata, dir_rdata, port_latch;
  logic [7:0]  ram_rdata, acc, stack_pointer, dir_addr, dir_wdata, ram_addr, ram_wdata;
  logic        busy, done, carry, pc_load, dir_we, ram_we, prio_release, int_hold, illegal;
  logic [15:0] program_counter;
  logic [1:0]  instr_len;
  logic [7:0]  mem [256];
  logic [7:0]  e_acc, wa, wd;
  logic        e_cy;
  int          wn, pr_n, error_cnt, checks, cyc_n;
  logic [7:0]  ops [12] = '{OP_OR_A_REG, OP_OR_A_DIR, OP_OR_A_IND, OP_OR_A_IMM, OP_OR_DIR_A,
    OP_OR_DIR_IMM, OP_OR_C_BIT, OP_OR_C_NBIT, OP_ROT_LEFT, OP_ROT_LEFT_CY, OP_ROT_RIGHT,
    OP_ROT_RIGHT_CY};
  int          nb [12] = '{1, 2, 1, 2, 2, 3, 2, 2, 1, 1, 1, 1};
  assign ram_rdata = mem[ram_addr];
  orx_core orx_core_i (.clk(clk), .rstn(rstn), .ce(ce), .instr_valid(instr_valid),
    .opcode(opcode), .operand1(operand1), .operand2(operand2), .reg_rdata(reg_rdata),
    .ind_rdata(ind_rdata), .dir_rdata(dir_rdata), .dir_is_port(dir_is_port),
    .port_latch(port_latch), .bit_value(bit_value), .ram_rdata(ram_rdata),
    .int_pending_low(int_pending_low), .busy(busy), .done(done), .acc(acc), .carry(carry),
    .stack_pointer(stack_pointer), .program_counter(program_counter), .instr_len(instr_len),
    .pc_load(pc_load), .dir_we(dir_we), .dir_addr(dir_addr), .dir_wdata(dir_wdata),
    .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .prio_release(prio_release), .int_hold(int_hold), .illegal(illegal));
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc_n++;
    if (ram_we) mem[ram_addr] <= ram_wdata;
    if (dir_we) begin
      wa <= dir_addr;
      wd <= dir_wdata;
      wn++;
    end
    if (prio_release) pr_n++;
    if (cyc_n == 5000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string n, logic [39:0] e, logic [39:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [8:0] rot_exp(logic [7:0] op, logic [7:0] a, logic c);
    case (op)
      OP_ROT_LEFT:    return {c, a[6:0], a[7]};
      OP_ROT_LEFT_CY: return {a, c};
      OP_ROT_RIGHT:   return {c, a[0], a[7:1]};
      default:        return {a[0], c, a[7:1]};
    endcase
  endfunction
  task automatic do_reset();
    @(negedge clk);
    rstn = 1'b0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    e_acc = ACC_RST;
    e_cy = 1'b0;
    pr_n = 0;
    wn = 0;
    chk("reset", {ACC_RST, 1'b0, SP_RST, PC_RST}, {acc, carry, stack_pointer, program_counter});
  endtask
  task automatic run(logic [7:0] op, logic [7:0] o1, int cyc, int len);
    int k;
    @(negedge clk);
    opcode = op;
    operand1 = o1;
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    chk("busy", cyc > 1, busy);
    for (k = 1; k < 9 && done !== 1'b1; k++) @(negedge clk);
    chk("cycles", cyc, k);
    chk("length", len, instr_len);
  endtask
  task automatic rand_op();
    logic [7:0] op;
    logic [7:0] o1;
    logic [7:0] old;
    int s;
    s = $urandom_range(0, 11);
    op = ops[s];
    if (s == 0) op = op | 8'($urandom_range(0, 7));
    if (s == 2) op = op | 8'($urandom_range(0, 1));
    o1 = 8'($urandom);
    operand2 = 8'($urandom);
    reg_rdata = 8'($urandom);
    ind_rdata = 8'($urandom);
    dir_rdata = 8'($urandom);
    port_latch = 8'($urandom);
    bit_value = 1'($urandom);
    dir_is_port = (s == 4 || s == 5) && $urandom_range(0, 1) == 1;
    old = dir_is_port ? port_latch : dir_rdata;
    wn = 0;
    run(op, o1, nb[s], nb[s]);
    case (s)
      0: e_acc |= reg_rdata;
      1: e_acc |= dir_rdata;
      2: e_acc |= ind_rdata;
      3: e_acc |= o1;
      4: chk("dir_write", {o1, old | e_acc}, {wa, wd});
      5: chk("dir_write", {o1, old | operand2}, {wa, wd});
      6: e_cy |= bit_value;
      7: e_cy |= !bit_value;
      default: {e_cy, e_acc} = rot_exp(op, e_acc, e_cy);
    endcase
    chk("dir_writes", s == 4 || s == 5, wn);
    chk("acc_carry", {e_acc, e_cy}, {acc, carry});
  endtask
  initial begin
    {rstn, instr_valid, dir_is_port, bit_value, int_pending_low, clk} = '0;
    {opcode, operand1, operand2, reg_rdata, ind_rdata, dir_rdata, port_latch} = '0;
    ce = 1'b1;
    {error_cnt, checks, cyc_n} = '0;
    void'($urandom(31));
    foreach (mem[i]) mem[i] = 8'($urandom);
    for (int n = 0; n < 16; n++) begin
      do_reset();
      repeat (8) rand_op();
    end
    // ****************************************
    // stack, return and illegal corner cases
    // ****************************************
    do_reset();
    run(OP_OR_A_IMM, 8'h96, 2, 2);
    bit_value = 1'b1;
    run(OP_OR_C_BIT, 8'h20, 2, 2);
    e_acc = 8'h96;
    e_cy = 1'b1;
    mem[8'h07] = 8'hfe;
    run(OP_POP, 8'h81, 2, 2);
    chk("sp_self_pop", {1'b0, 8'hfe}, {wn != 0, stack_pointer});
    dir_rdata = 8'h5a;
    run(OP_PUSH, 8'h30, 2, 2);
    dir_rdata = 8'ha5;
    run(OP_PUSH, 8'h31, 2, 2);
    chk("push_wrap", {8'h00, 8'h5a, 8'ha5}, {stack_pointer, mem[8'hff], mem[8'h00]});
    run(OP_POP, 8'h44, 2, 2);
    chk("pop_write", {1'b1, 8'h44, 8'ha5, 8'hff}, {wn == 1, wa, wd, stack_pointer});
    run(OP_CALL_EXIT, 8'h00, 2, 1);
    chk("call_exit", {mem[8'hff], mem[8'hfe], 8'hfd, 1'b0},
        {program_counter, stack_pointer, pr_n != 0 || prio_release});
    int_pending_low = 1'b1;
    run(OP_INT_EXIT, 8'h00, 2, 1);
    chk("int_exit", {mem[8'hfd], mem[8'hfc], 8'hfb, 3'b111},
        {program_counter, stack_pointer, pr_n == 0, prio_release, int_hold});
    chk("regs_kept", {e_acc, e_cy}, {acc, carry});
    int_pending_low = 1'b0;
    run(OP_ROT_RIGHT, 8'h00, 1, 1);
    chk("hold_one", 1'b1, int_hold);
    {e_cy, e_acc} = rot_exp(OP_ROT_RIGHT, e_acc, e_cy);
    repeat (2) @(negedge clk);
    chk("hold_clear", {1'b0, e_acc, e_cy}, {int_hold, acc, carry});
    ce = 1'b0;
    opcode = OP_ROT_LEFT;
    instr_valid = 1'b1;
    repeat (3) @(negedge clk);
    chk("ce_freeze", {e_acc, e_cy, 2'b00}, {acc, carry, done, busy});
    ce = 1'b1;
    opcode = 8'ha5;
    @(negedge clk);
    instr_valid = 1'b0;
    repeat (3) @(negedge clk);
    chk("illegal", {1'b1, e_acc, e_cy}, {illegal, acc, carry});
    rand_op();
    chk("illegal_clear", 1'b0, illegal);
    test_done();
  end
endmodule
